// ===== crf_bank_mem.sv
// banked register storage with byte-enable write and registered read
`timescale 1ns/1ps

module crf_bank_mem #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 64,
	parameter int AW = 6
) (
	input wire logic sys_clk,
	input wire logic we,
	input wire logic [WIDTH/8-1:0] wbe,
	input wire logic [AW-1:0] waddr,
	input wire logic [WIDTH-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [WIDTH-1:0] rdata
);

	logic [WIDTH-1:0] store [DEPTH];

	genvar gi;
	generate
		for (gi = 0; gi < WIDTH / 8; gi++) begin : g_lane
			always_ff @(posedge sys_clk) begin
				if (we && wbe[gi]) begin
					store[waddr][gi*8 +: 8] <= wdata[gi*8 +: 8];
				end
			end
		end
	endgenerate

	always_ff @(posedge sys_clk) begin
		rdata <= store[raddr];
	end

endmodule

// ===== crf_bus_model.sv
// bus side model: free running bus clock and external i/o transaction log
`timescale 1ns/1ps

module crf_bus_model import crf_pkg::*; (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic slow,
	input wire crf_io_t io_bus,
	output logic bus_clock,
	output logic [15:0] io_count,
	output logic [31:0] io_addr
);
	logic [1:0] div_reg;

	// slow mode toggles every fourth cycle
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			div_reg <= 2'h0;
			bus_clock <= 1'b0;
		end else begin
			div_reg <= div_reg + 2'h1;
			if (!slow || div_reg == 2'h3) begin
				bus_clock <= ~bus_clock;
			end
		end
	end

	// a peripheral sees one strobe per transaction
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			io_count <= 16'h0;
			io_addr <= 32'h0;
		end else if (io_bus.strobe) begin
			io_count <= io_count + 16'h1;
			io_addr <= io_bus.addr;
		end
	end
endmodule

// ===== crf_core.sv
// core register file: banked files, pc, sp, control select, i/o address forming
`timescale 1ns/1ps
`include "crf_defines.svh"

// Operation
// - reset selects bank zero primary; one file active
// - pair exchange moves 16 or 32 bits
// - pair upper half via swap or long load
// - flags hold eight bits, two reserved
// - index registers 32 bits, byte halves addressable
// - modes 2/3 vector uses upper interrupt bits
// - assigned vector from i, base, fixed code
// - native pc upper zero, no carry
// - extended pc increments full 32 bits
// - r register plain read/write, never refreshed
// - sp wraps 2^16 native, 2^32 extended
// - sp upper half loaded in long mode
// - select register whole, byte, common byte access
// - select register read back whole; reset clears it
// - lsb at lowest address, upper lane
// - even address aligned, odd unaligned
// - external i/o is one transaction
// - i/o address formed per instruction form
// - on-chip access is two-cycle pseudo-transaction
// - on-chip space via page-zero ops; 17h-19h
// - version register at 0ffh, read-only
// - data references use full 32-bit address
// - native after reset; extended until reset
module crf_core import crf_pkg::*; #(
	parameter logic [7:0] VERSION_CODE = 8'h5a // arbitrary value
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic bus_clock,
	input wire crf_req_t req,
	output logic ready,
	output crf_rsp_t rsp,
	output logic [31:0] control_select_register,
	output logic ext_mode,
	output logic [31:0] program_counter,
	output logic [31:0] stack_pointer,
	output crf_io_t io_bus,
	output crf_mem_t mem_ref,
	output logic [31:0] int_vector
);

	// ==========================================================
	// decode helpers
	function automatic logic [5:0] reg_addr(input crf_reg_t sel, input logic [31:0] sr,
			input logic other);
		logic [1:0] bank;
		logic alt;
		bank = sr[`CRF_SR_GEN_BANK_LO +: 2];
		alt = sr[`CRF_SR_GEN_ALT_BIT];
		case (sel)
			CRF_REG_AF: alt = sr[`CRF_SR_AF_ALT_BIT];
			CRF_REG_IX: begin
				bank = sr[`CRF_SR_IX_BANK_LO +: 2];
				alt = sr[`CRF_SR_IX_ALT_BIT];
			end
			CRF_REG_IY: begin
				bank = sr[`CRF_SR_IY_BANK_LO +: 2];
				alt = sr[`CRF_SR_IY_ALT_BIT];
			end
			default: ;
		endcase
		return {bank, alt ^ other, sel};
	endfunction

	function automatic logic [3:0] be_of(input crf_size_t size, input logic lw);
		unique case (size)
			CRF_SZ_LO8: return 4'h1;
			CRF_SZ_HI8: return 4'h2;
			CRF_SZ_WORD: return lw ? 4'hf : 4'h3;
			CRF_SZ_LONG: return 4'hf;
		endcase
	endfunction

	function automatic logic [31:0] mask_of(input logic [3:0] be);
		return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction

	// ==========================================================
	// state
	crf_state_t state_reg, state_next;
	crf_req_t cur_reg;
	logic ready_reg, ready_next;
	logic [31:0] sr_reg, pc_reg, sp_reg, tmp_reg;
	logic xm_reg;
	logic [23:0] i_reg;
	logic [7:0] r_reg, ie_reg, avb_reg, tb_reg;
	logic pseudo_reg, pseudo_next, bclk_prev_reg;
	logic [1:0] bcnt_reg;
	crf_rsp_t rsp_reg;
	crf_io_t io_reg;
	crf_mem_t mem_reg;
	logic [31:0] vec_reg;

	logic accept, lw, bclk_rise;
	logic we;
	logic [3:0] wbe;
	logic [5:0] waddr, raddr;
	logic [31:0] wdata, rdata;

	assign accept = req.valid && ready_reg;
	assign lw = sr_reg[`CRF_SR_LW_BIT];
	assign bclk_rise = bus_clock && !bclk_prev_reg;

	crf_bank_mem #(.WIDTH(32), .DEPTH(64), .AW(6)) u_mem (
		.sys_clk(sys_clk),
		.we(we),
		.wbe(wbe),
		.waddr(waddr),
		.wdata(wdata),
		.raddr(raddr),
		.rdata(rdata)
	);

	// ==========================================================
	// sequencing and storage writes
	always_comb begin
		state_next = state_reg;
		we = 1'b0;
		wbe = 4'h0;
		waddr = reg_addr(req.sel, sr_reg, 1'b0);
		wdata = req.wdata;
		raddr = reg_addr(req.sel, sr_reg, 1'b0);
		unique case (state_reg)
			CRF_ST_IDLE: begin
				if (accept) begin
					unique case (req.op)
						CRF_OP_REG_WR: begin
							we = 1'b1;
							wbe = be_of(req.size, lw);
							if (req.size == CRF_SZ_HI8) begin
								wdata = {16'h0000, req.wdata[7:0], 8'h00};
							end
						end
						CRF_OP_FLAG_WR: begin
							we = 1'b1;
							wbe = 4'h1;
							waddr = reg_addr(CRF_REG_AF, sr_reg, 1'b0);
							wdata = {24'h00_0000, req.wdata[7:0] & ~`CRF_F_RSVD_MASK};
						end
						CRF_OP_IO_EXT: begin
							raddr = reg_addr(req.sub == 3'h0 ? CRF_REG_AF : CRF_REG_BC, sr_reg, 1'b0);
							state_next = CRF_ST_RD;
						end
						CRF_OP_REG_RD, CRF_OP_SWAP, CRF_OP_EX_PAIR, CRF_OP_MEM_REF: begin
							state_next = CRF_ST_RD;
						end
						default: ;
					endcase
				end
			end
			CRF_ST_RD: begin
				state_next = CRF_ST_IDLE;
				waddr = reg_addr(cur_reg.sel, sr_reg, 1'b0);
				raddr = reg_addr(cur_reg.sel, sr_reg, 1'b1);
				if (cur_reg.op == CRF_OP_SWAP) begin
					we = 1'b1;
					wbe = 4'hf;
					wdata = {rdata[15:0], rdata[31:16]};
				end else if (cur_reg.op == CRF_OP_EX_PAIR) begin
					state_next = CRF_ST_X2;
				end
			end
			CRF_ST_X2: begin
				state_next = CRF_ST_X3;
				we = 1'b1;
				wbe = be_of(CRF_SZ_WORD, lw);
				waddr = reg_addr(cur_reg.sel, sr_reg, 1'b0);
				wdata = rdata;
			end
			CRF_ST_X3: begin
				state_next = CRF_ST_IDLE;
				we = 1'b1;
				wbe = be_of(CRF_SZ_WORD, lw);
				waddr = reg_addr(cur_reg.sel, sr_reg, 1'b1);
				wdata = tmp_reg;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			state_reg <= CRF_ST_IDLE;
			cur_reg <= '0;
			tmp_reg <= 32'h0000_0000;
		end else begin
			state_reg <= state_next;
			if (accept) begin
				cur_reg <= req;
			end
			if (state_reg == CRF_ST_RD) begin
				tmp_reg <= rdata;
			end
		end
	end

	// ==========================================================
	// ready: low while a sequence or pseudo-transaction runs
	always_comb begin
		pseudo_next = pseudo_reg;
		if (accept && (req.op == CRF_OP_ONCHIP_RD || req.op == CRF_OP_ONCHIP_WR)) begin
			pseudo_next = 1'b1;
		end else if (pseudo_reg && bclk_rise && bcnt_reg == `CRF_PSEUDO_BUS_CYCLES - 2'h1) begin
			pseudo_next = 1'b0;
		end
		ready_next = (state_next == CRF_ST_IDLE) && !pseudo_next;
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			ready_reg <= 1'b0;
		end else begin
			ready_reg <= ready_next;
		end
	end

	// ==========================================================
	// control select register and mode
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			sr_reg <= `CRF_RST_SELECT;
		end else if (accept) begin
			unique case (req.op)
				CRF_OP_EX_AF: sr_reg[`CRF_SR_AF_ALT_BIT] <= ~sr_reg[`CRF_SR_AF_ALT_BIT];
				CRF_OP_EX_GEN: sr_reg[`CRF_SR_GEN_ALT_BIT] <= ~sr_reg[`CRF_SR_GEN_ALT_BIT];
				CRF_OP_EX_IX: sr_reg[`CRF_SR_IX_ALT_BIT] <= ~sr_reg[`CRF_SR_IX_ALT_BIT];
				CRF_OP_EX_IY: sr_reg[`CRF_SR_IY_ALT_BIT] <= ~sr_reg[`CRF_SR_IY_ALT_BIT];
				CRF_OP_EX_ALL: begin
					sr_reg[`CRF_SR_GEN_ALT_BIT] <= ~sr_reg[`CRF_SR_GEN_ALT_BIT];
					sr_reg[`CRF_SR_IX_ALT_BIT] <= ~sr_reg[`CRF_SR_IX_ALT_BIT];
					sr_reg[`CRF_SR_IY_ALT_BIT] <= ~sr_reg[`CRF_SR_IY_ALT_BIT];
				end
				CRF_OP_SET_XM: sr_reg[`CRF_SR_XM_BIT] <= 1'b1;
				CRF_OP_SPEC_WR: begin
					unique case (req.sub)
						3'h3: sr_reg <= (req.wdata & ~(32'h1 << `CRF_SR_XM_BIT))
								| (sr_reg & (32'h1 << `CRF_SR_XM_BIT));
						3'h4: sr_reg[15:8] <= req.wdata[7:0];
						3'h5: sr_reg[23:16] <= req.wdata[7:0];
						3'h6: sr_reg[31:24] <= req.wdata[7:0];
						3'h7: sr_reg[31:8] <= {3{req.wdata[7:0]}};
						default: ;
					endcase
				end
				default: ;
			endcase
		end
	end

	// ==========================================================
	// program counter
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			pc_reg <= `CRF_RST_PC;
		end else if (accept && req.op == CRF_OP_PC) begin
			if (xm_reg) begin
				pc_reg <= (req.sub == 3'h0) ? pc_reg + req.wdata : req.wdata;
			end else begin
				pc_reg[31:16] <= 16'h0000;
				pc_reg[15:0] <= (req.sub == 3'h0) ? pc_reg[15:0] + req.wdata[15:0] : req.wdata[15:0];
			end
		end
	end

	// ==========================================================
	// stack pointer
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			sp_reg <= `CRF_RST_SP;
		end else if (accept && req.op == CRF_OP_SP_ADJ) begin
			if (xm_reg) begin
				sp_reg <= sp_reg + req.wdata;
			end else begin
				sp_reg[15:0] <= sp_reg[15:0] + req.wdata[15:0];
			end
		end else if (accept && req.op == CRF_OP_SPEC_WR && req.sub == 3'h2) begin
			sp_reg[15:0] <= req.wdata[15:0];
			if (lw || req.size == CRF_SZ_LONG) begin
				sp_reg[31:16] <= req.wdata[31:16];
			end
		end
	end

	// ==========================================================
	// interrupt and r registers
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			i_reg <= `CRF_RST_I;
			r_reg <= `CRF_RST_R;
		end else if (accept && req.op == CRF_OP_SPEC_WR) begin
			if (req.sub == 3'h0) begin
				i_reg <= req.wdata[23:0];
			end
			if (req.sub == 3'h1) begin
				r_reg <= req.wdata[7:0];
			end
		end
	end

	// ==========================================================
	// on-chip i/o registers
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			ie_reg <= `CRF_RST_INT_ENABLE;
			avb_reg <= `CRF_RST_VEC_BASE;
			tb_reg <= `CRF_RST_TRAP_BREAK;
		end else if (accept && req.op == CRF_OP_ONCHIP_WR) begin
			unique case (req.aux[7:0])
				`CRF_OFS_INT_ENABLE: ie_reg <= req.wdata[7:0];
				`CRF_OFS_VEC_BASE: avb_reg <= req.wdata[7:0];
				`CRF_OFS_TRAP_BREAK: tb_reg <= req.wdata[7:0];
				default: ; // version is read-only
			endcase
		end
	end

	// ==========================================================
	// pseudo-transaction timing on the bus clock
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			pseudo_reg <= 1'b0;
			bcnt_reg <= 2'h0;
			bclk_prev_reg <= 1'b0;
		end else begin
			bclk_prev_reg <= bus_clock;
			pseudo_reg <= pseudo_next;
			if (!pseudo_reg) begin
				bcnt_reg <= 2'h0;
			end else if (bclk_rise) begin
				bcnt_reg <= bcnt_reg + 2'h1;
			end
		end
	end

	// ==========================================================
	// answers to the execution core
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			rsp_reg <= '0;
		end else begin
			rsp_reg.done <= 1'b0;
			if (state_reg == CRF_ST_RD && cur_reg.op == CRF_OP_REG_RD) begin
				rsp_reg.done <= 1'b1;
				rsp_reg.data <= rdata & mask_of(be_of(cur_reg.size, lw));
				if (cur_reg.size == CRF_SZ_HI8) begin
					rsp_reg.data <= {24'h00_0000, rdata[15:8]};
				end
			end else if ((state_reg == CRF_ST_RD && cur_reg.op != CRF_OP_EX_PAIR)
					|| state_reg == CRF_ST_X3) begin
				rsp_reg.done <= 1'b1;
				rsp_reg.data <= 32'h0000_0000;
			end else if (accept && state_next == CRF_ST_IDLE) begin
				rsp_reg.done <= 1'b1;
				rsp_reg.data <= 32'h0000_0000;
				if (req.op == CRF_OP_SPEC_RD) begin
					unique case (req.sub)
						3'h0: rsp_reg.data <= {8'h00, i_reg};
						3'h1: rsp_reg.data <= {24'h00_0000, r_reg};
						3'h2: rsp_reg.data <= sp_reg;
						3'h3: rsp_reg.data <= pc_reg;
						default: rsp_reg.data <= sr_reg;
					endcase
				end else if (req.op == CRF_OP_ONCHIP_RD) begin
					unique case (req.aux[7:0])
						`CRF_OFS_INT_ENABLE: rsp_reg.data <= {24'h00_0000, ie_reg};
						`CRF_OFS_VEC_BASE: rsp_reg.data <= {24'h00_0000, avb_reg};
						`CRF_OFS_TRAP_BREAK: rsp_reg.data <= {24'h00_0000, tb_reg};
						`CRF_OFS_VERSION: rsp_reg.data <= {24'h00_0000, VERSION_CODE};
						default: ;
					endcase
				end
			end
		end
	end

	// ==========================================================
	// i/o address bus
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			io_reg <= '0;
		end else begin
			io_reg.strobe <= 1'b0;
			io_reg.pseudo <= pseudo_next; // controls stay inactive
			if (accept && (req.op == CRF_OP_ONCHIP_RD || req.op == CRF_OP_ONCHIP_WR)) begin
				io_reg.addr <= {24'h00_0000, req.aux[7:0]};
			end else if (state_reg == CRF_ST_RD && cur_reg.op == CRF_OP_IO_EXT) begin
				io_reg.strobe <= 1'b1; // single transaction
				unique case (cur_reg.sub)
					3'h0: io_reg.addr <= {16'h0000, rdata[15:8], cur_reg.aux[7:0]};
					3'h1: io_reg.addr <= rdata;
					3'h2: io_reg.addr <= {16'h0000, cur_reg.wdata[15:0]};
					3'h3: io_reg.addr <= {8'h00, cur_reg.wdata[23:0]};
					default: io_reg.addr <= cur_reg.wdata;
				endcase
			end
		end
	end

	// ==========================================================
	// memory reference address and byte lanes
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			mem_reg <= '0;
		end else begin
			mem_reg.valid <= 1'b0;
			if (state_reg == CRF_ST_RD && cur_reg.op == CRF_OP_MEM_REF) begin
				mem_reg.valid <= 1'b1;
				mem_reg.addr <= rdata;
				mem_reg.aligned <= ~rdata[0];
				mem_reg.lanes <= {cur_reg.wdata[7:0], cur_reg.wdata[15:8]};
			end
		end
	end

	// ==========================================================
	// interrupt vector forming
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			vec_reg <= 32'h0000_0000;
		end else if (accept && req.op == CRF_OP_VEC) begin
			unique case (req.sub)
				3'h0: vec_reg <= {i_reg, req.aux[7:0]};
				3'h1: vec_reg <= {i_reg[23:8], req.aux};
				3'h2: vec_reg <= {i_reg[23:8], avb_reg[7:1], `CRF_VEC_CODE_IN1};
				3'h3: vec_reg <= {i_reg[23:8], avb_reg[7:1], `CRF_VEC_CODE_IN2};
				default: vec_reg <= {i_reg[23:8], avb_reg[7:1], `CRF_VEC_CODE_IN3};
			endcase
		end
	end

	assign ready = ready_reg;
	assign rsp = rsp_reg;
	assign control_select_register = sr_reg;
	assign xm_reg = sr_reg[`CRF_SR_XM_BIT];
	assign ext_mode = xm_reg;
	assign program_counter = pc_reg;
	assign stack_pointer = sp_reg;
	assign io_bus = io_reg;
	assign mem_ref = mem_reg;
	assign int_vector = vec_reg;

endmodule

// ===== crf_core_assertions.sv
// checker: timing and value properties on the register file ports
`timescale 1ns/1ps

module crf_core_assertions import crf_pkg::*; (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic bus_clock,
	input wire crf_req_t req,
	input wire logic ready,
	input wire crf_rsp_t rsp,
	input wire logic [31:0] control_select_register,
	input wire logic ext_mode,
	input wire logic [31:0] program_counter,
	input wire logic [31:0] stack_pointer,
	input wire crf_io_t io_bus,
	input wire crf_mem_t mem_ref,
	input wire logic [31:0] int_vector
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	logic tk;
	assign tk = req.valid && ready;

	// ==========================================================
	// properties
	a_reset_state: assert property (
		$rose(nrst) |-> control_select_register == 32'h0 && !ext_mode)
		else $error("state not cleared by reset");
	a_native_pc: assert property (
		!ext_mode |-> program_counter[31:16] == 16'h0)
		else $error("native pc upper half not zero");
	a_ext_sticky: assert property (ext_mode |=> ext_mode)
		else $error("extended mode left without reset");
	a_sr_mirror: assert property (control_select_register[1] == ext_mode)
		else $error("select bit one differs from mode");
	a_io_once: assert property (
		tk && req.op == CRF_OP_IO_EXT |-> ##2 io_bus.strobe ##1 !io_bus.strobe)
		else $error("external i/o not one transaction");
	a_pseudo_quiet: assert property (
		io_bus.pseudo |-> !io_bus.strobe && io_bus.addr[31:8] == 24'h0)
		else $error("pseudo transaction drives bus");
	a_onchip_start: assert property (
		tk && (req.op == CRF_OP_ONCHIP_RD || req.op == CRF_OP_ONCHIP_WR)
		|=> io_bus.pseudo && rsp.done && io_bus.addr == {24'h0, $past(req.aux[7:0])})
		else $error("on-chip access start wrong");
	a_mem_align: assert property (
		mem_ref.valid |-> mem_ref.aligned == !mem_ref.addr[0])
		else $error("alignment flag wrong");
	a_sp_native: assert property (
		tk && req.op == CRF_OP_SP_ADJ && !ext_mode
		|=> stack_pointer[31:16] == $past(stack_pointer[31:16]))
		else $error("native stack carried into upper half");
	a_pair_walk: assert property (
		tk && req.op == CRF_OP_EX_PAIR |=> !ready [*3] ##1 (ready && rsp.done))
		else $error("pair exchange timing wrong");
endmodule

bind crf_core crf_core_assertions u_chk (.sys_clk(sys_clk), .nrst(nrst), .bus_clock(bus_clock),
	.req(req), .ready(ready), .rsp(rsp), .control_select_register(control_select_register),
	.ext_mode(ext_mode), .program_counter(program_counter), .stack_pointer(stack_pointer),
	.io_bus(io_bus), .mem_ref(mem_ref), .int_vector(int_vector));

// ===== crf_core_tb_top.sv
// testbench of the core register file
`timescale 1ns/1ps

module crf_core_tb_top import crf_pkg::*;;
	localparam logic [7:0] VER = 8'h3c; // arbitrary value
	localparam crf_reg_t R_AF = CRF_REG_AF, R_BC = CRF_REG_BC, R_HL = CRF_REG_HL, R_IX = CRF_REG_IX;
	localparam crf_size_t S_LO = CRF_SZ_LO8, S_HI = CRF_SZ_HI8, S_WD = CRF_SZ_WORD;
	localparam crf_size_t S_LG = CRF_SZ_LONG;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic slow = 1'b0;
	crf_req_t req = '0;
	logic bus_clock, ready, ext_mode;
	crf_rsp_t rsp;
	logic [31:0] csr, pc, sp, int_vector, io_addr, x, y, v, w;
	crf_io_t io_bus;
	crf_mem_t mem_ref;
	logic [15:0] io_count, k;
	logic [32:0] ent;
	logic [32:0] ex_q[$];
	logic [31:0] lfsr = 32'h339994c3;
	logic [7:0] ports[3] = '{8'h17, 8'h18, 8'h19};
	int bad_count = 0;
	int num_checks = 0;
	int done_cnt = 0;

	always #5 sys_clk = ~sys_clk;

	crf_core #(.VERSION_CODE(VER)) uut (.sys_clk(sys_clk), .nrst(nrst), .bus_clock(bus_clock),
		.req(req), .ready(ready), .rsp(rsp), .control_select_register(csr),
		.ext_mode(ext_mode), .program_counter(pc), .stack_pointer(sp), .io_bus(io_bus),
		.mem_ref(mem_ref), .int_vector(int_vector));
	crf_bus_model u_bus (.sys_clk(sys_clk), .nrst(nrst), .slow(slow), .io_bus(io_bus),
		.bus_clock(bus_clock), .io_count(io_count), .io_addr(io_addr));

	// ==========================================================
	// helpers
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask

	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction

	// one request: wait ready, hold one edge, then wait for its done
	task automatic go(crf_op_t o, crf_reg_t s, crf_size_t z, logic [2:0] u, logic [15:0] a,
		logic [31:0] d, logic c = 1'b0, logic [31:0] e = 32'h0);
		int n;
		int kd;
		n = 0;
		while (ready !== 1'b1) begin
			@(posedge sys_clk);
			#1;
			if (++n > 200) begin
				bad_count++;
				conclude();
			end
		end
		ex_q.push_back({c, e});
		kd = done_cnt;
		req = '{1'b1, o, s, z, u, a, d};
		@(posedge sys_clk);
		#1;
		req.valid = 1'b0;
		n = 0;
		while (done_cnt == kd) begin
			@(posedge sys_clk);
			#1;
			if (++n > 200) begin
				bad_count++;
				conclude();
			end
		end
	endtask

	// ==========================================================
	// result monitor
	always @(posedge sys_clk) begin
		if (nrst && rsp.done === 1'b1) begin
			done_cnt++;
			if (ex_q.size() == 0) begin
				bad_count++;
				$display("MISMATCH done exp none got %h", rsp.data);
			end else begin
				ent = ex_q.pop_front();
				if (ent[32]) begin
					chk("rsp_data", ent[31:0], rsp.data);
				end
			end
		end
	end

	// ==========================================================
	// main sequence
	initial begin
		repeat (5) @(posedge sys_clk);
		#1;
		nrst = 1'b1;
		@(posedge sys_clk);
		#1;
		chk("sr", 32'h0, csr);
		chk("pc_sp", 32'h0, pc | sp | {31'h0, ext_mode});
		go(CRF_OP_SPEC_WR, R_AF, S_LG, 3'h7, 16'h0, 32'ha5);
		chk("sr", 32'ha5a5_a500, csr);
		go(CRF_OP_SPEC_WR, R_AF, S_LG, 3'h5, 16'h0, 32'h3c);
		go(CRF_OP_SPEC_RD, R_AF, S_LG, 3'h4, 16'h0, 32'h0, 1'b1, 32'ha53c_a500);
		go(CRF_OP_SPEC_WR, R_AF, S_LG, 3'h3, 16'h0, 32'hffff_ffff);
		chk("sr", 32'hffff_fffd, csr);
		go(CRF_OP_SPEC_WR, R_AF, S_LG, 3'h3, 16'h0, 32'h0);
		x = rnd();
		y = rnd();
		go(CRF_OP_SPEC_WR, R_AF, S_LG, 3'h1, 16'h0, x);
		go(CRF_OP_SPEC_RD, R_AF, S_LG, 3'h1, 16'h0, 32'h0, 1'b1, {24'h0, x[7:0]});
		go(CRF_OP_REG_WR, R_BC, S_LG, 3'h0, 16'h0, x);
		go(CRF_OP_EX_GEN, R_BC, S_LG, 3'h0, 16'h0, 32'h0);
		chk("gen_alt", 32'h400, csr & 32'h400);
		go(CRF_OP_REG_WR, R_BC, S_LG, 3'h0, 16'h0, y);
		go(CRF_OP_EX_GEN, R_BC, S_LG, 3'h0, 16'h0, 32'h0);
		chk("gen_alt", 32'h0, csr & 32'h400);
		go(CRF_OP_EX_PAIR, R_BC, S_LG, 3'h0, 16'h0, 32'h0);
		go(CRF_OP_REG_RD, R_BC, S_LG, 3'h0, 16'h0, 32'h0, 1'b1, {x[31:16], y[15:0]});
		go(CRF_OP_SPEC_WR, R_AF, S_LG, 3'h3, 16'h0, 32'h1);
		go(CRF_OP_EX_PAIR, R_BC, S_LG, 3'h0, 16'h0, 32'h0);
		go(CRF_OP_REG_RD, R_BC, S_LG, 3'h0, 16'h0, 32'h0, 1'b1, {y[31:16], x[15:0]});
		v = rnd();
		go(CRF_OP_REG_WR, R_HL, S_WD, 3'h0, 16'h0, v);
		go(CRF_OP_REG_RD, R_HL, S_LG, 3'h0, 16'h0, 32'h0, 1'b1, v);
		go(CRF_OP_SPEC_WR, R_AF, S_LG, 3'h3, 16'h0, 32'h0);
		w = rnd();
		go(CRF_OP_REG_WR, R_HL, S_WD, 3'h0, 16'h0, w);
		go(CRF_OP_REG_RD, R_HL, S_LG, 3'h0, 16'h0, 32'h0, 1'b1, {v[31:16], w[15:0]});
		go(CRF_OP_REG_WR, R_IX, S_LG, 3'h0, 16'h0, x);
		go(CRF_OP_REG_WR, R_IX, S_HI, 3'h0, 16'h0, y);
		go(CRF_OP_REG_RD, R_IX, S_LG, 3'h0, 16'h0, 32'h0, 1'b1, {x[31:16], y[7:0], x[7:0]});
		go(CRF_OP_FLAG_WR, R_AF, S_LO, 3'h0, 16'h0, 32'hff);
		go(CRF_OP_REG_RD, R_AF, S_LO, 3'h0, 16'h0, 32'h0, 1'b1, 32'hd7);
		for (int i = 0; i < 2; i++) begin
			v = rnd();
			v[0] = i[0];
			go(CRF_OP_REG_WR, R_HL, S_LG, 3'h0, 16'h0, v);
			go(CRF_OP_MEM_REF, R_HL, S_LG, 3'h0, 16'h0, 32'h0);
			chk("mem_addr", v, mem_ref.addr);
			chk("aligned", {31'h0, ~v[0]}, {31'h0, mem_ref.aligned});
		end
		go(CRF_OP_REG_WR, R_AF, S_WD, 3'h0, 16'h0, {16'h0, y[15:8], 8'h0});
		for (int i = 0; i < 3; i++) begin
			v = rnd();
			k = io_count;
			go(CRF_OP_IO_EXT, R_BC, S_LG, i[2:0], v[15:0], v);
			w = (i == 0) ? {16'h0, y[15:8], v[7:0]} : (i == 1) ? {y[31:16], x[15:0]} : {16'h0, v[15:0]};
			chk("io_addr", w, io_addr);
			chk("io_count", {16'h0, k + 16'h1}, {16'h0, io_count});
		end
		v = rnd();
		go(CRF_OP_SPEC_WR, R_AF, S_LG, 3'h0, 16'h0, v);
		go(CRF_OP_VEC, R_AF, S_LG, 3'h0, y[15:0], 32'h0);
		chk("vec2", {v[23:0], y[7:0]}, int_vector);
		go(CRF_OP_VEC, R_AF, S_LG, 3'h1, y[15:0], 32'h0);
		chk("vec3", {v[23:8], y[15:0]}, int_vector);
		for (int i = 0; i < 3; i++) begin
			go(CRF_OP_VEC, R_AF, S_LG, 3'(i + 2), 16'h0, 32'h0);
			w = 32'h104 + 4 * i;
			chk("vec_code", w, {23'h0, int_vector[8:0]});
		end
		slow = 1'b1;
		for (int i = 0; i < 3; i++) begin
			v = rnd();
			go(CRF_OP_ONCHIP_WR, R_AF, S_LG, 3'h0, {8'h0, ports[i]}, {24'h0, v[7:0]});
			chk("pseudo", {24'h0, ports[i]}, io_bus.addr & {32{io_bus.pseudo}});
			go(CRF_OP_ONCHIP_RD, R_AF, S_LG, 3'h0, {8'h0, ports[i]}, 32'h0, 1'b1, {24'h0, v[7:0]});
		end
		go(CRF_OP_ONCHIP_WR, R_AF, S_LG, 3'h0, 16'hff, 32'h0);
		go(CRF_OP_ONCHIP_RD, R_AF, S_LG, 3'h0, 16'hff, 32'h0, 1'b1, {24'h0, VER});
		go(CRF_OP_ONCHIP_RD, R_AF, S_LG, 3'h0, 16'h20, 32'h0, 1'b1, 32'h0);
		slow = 1'b0;
		go(CRF_OP_PC, R_AF, S_LG, 3'h1, 16'h0, 32'h1234_fffe);
		chk("pc", 32'h0000_fffe, pc);
		go(CRF_OP_PC, R_AF, S_LG, 3'h0, 16'h0, 32'h2);
		chk("pc", 32'h0, pc);
		go(CRF_OP_SPEC_WR, R_AF, S_WD, 3'h2, 16'h0, 32'h0001_fffe);
		chk("sp", 32'h0000_fffe, sp);
		go(CRF_OP_SPEC_WR, R_AF, S_LG, 3'h3, 16'h0, 32'h1);
		go(CRF_OP_SPEC_WR, R_AF, S_LG, 3'h2, 16'h0, 32'h0001_fffe);
		chk("sp", 32'h0001_fffe, sp);
		go(CRF_OP_SP_ADJ, R_AF, S_LG, 3'h0, 16'h0, 32'h2);
		chk("sp", 32'h0001_0000, sp);
		go(CRF_OP_SPEC_WR, R_AF, S_LG, 3'h2, 16'h0, 32'h0001_fffe);
		go(CRF_OP_SET_XM, R_AF, S_LG, 3'h0, 16'h0, 32'h0);
		go(CRF_OP_SP_ADJ, R_AF, S_LG, 3'h0, 16'h0, 32'h2);
		chk("sp", 32'h0002_0000, sp);
		go(CRF_OP_PC, R_AF, S_LG, 3'h1, 16'h0, 32'h0000_ffff);
		go(CRF_OP_PC, R_AF, S_LG, 3'h0, 16'h0, 32'h1);
		chk("pc", 32'h0001_0000, pc);
		go(CRF_OP_SPEC_WR, R_AF, S_LG, 3'h3, 16'h0, 32'h0);
		chk("ext", 32'h1, {31'h0, ext_mode});
		nrst = 1'b0;
		repeat (5) @(posedge sys_clk);
		#1;
		chk("ext", 32'h0, {31'h0, ext_mode});
		chk("sr", 32'h0, csr);
		conclude();
	end
endmodule

// ===== crf_defines.svh
// constants of the core register file: on-chip offsets, reset values, field positions, counts
`ifndef CRF_DEFINES_SVH
`define CRF_DEFINES_SVH

// ==========================================================
// on-chip i/o offsets
`define CRF_OFS_INT_ENABLE 8'h17
`define CRF_OFS_VEC_BASE 8'h18
`define CRF_OFS_TRAP_BREAK 8'h19
`define CRF_OFS_VERSION 8'hff

// ==========================================================
// reset values
`define CRF_RST_INT_ENABLE 8'h00
`define CRF_RST_VEC_BASE 8'h00
`define CRF_RST_TRAP_BREAK 8'h00
`define CRF_RST_SELECT 32'h0000_0000
`define CRF_RST_PC 32'h0000_0000
`define CRF_RST_SP 32'h0000_0000
`define CRF_RST_I 24'h00_0000
`define CRF_RST_R 8'h00

// ==========================================================
// control select register field positions
`define CRF_SR_LW_BIT 0
`define CRF_SR_XM_BIT 1
`define CRF_SR_GEN_BANK_LO 8
`define CRF_SR_GEN_ALT_BIT 10
`define CRF_SR_AF_ALT_BIT 11
`define CRF_SR_IX_BANK_LO 16
`define CRF_SR_IX_ALT_BIT 18
`define CRF_SR_IY_BANK_LO 24
`define CRF_SR_IY_ALT_BIT 26

// ==========================================================
// flag register reserved bits, assigned vector codes, pseudo-transaction length
`define CRF_F_RSVD_MASK 8'h28
`define CRF_VEC_CODE_IN1 9'h104
`define CRF_VEC_CODE_IN2 9'h108
`define CRF_VEC_CODE_IN3 9'h10c
`define CRF_PSEUDO_BUS_CYCLES 2'h2

`endif

// ===== crf_pkg.sv
// types shared by the core register file modules
package crf_pkg;

	// ==========================================================
	// operations issued by the execution core
	typedef enum logic [4:0] {
		CRF_OP_NOP = 5'h00,
		CRF_OP_REG_RD = 5'h01,
		CRF_OP_REG_WR = 5'h02,
		CRF_OP_FLAG_WR = 5'h03,
		CRF_OP_SWAP = 5'h04,
		CRF_OP_EX_PAIR = 5'h05,
		CRF_OP_EX_AF = 5'h06,
		CRF_OP_EX_GEN = 5'h07,
		CRF_OP_EX_IX = 5'h08,
		CRF_OP_EX_IY = 5'h09,
		CRF_OP_EX_ALL = 5'h0a,
		CRF_OP_SPEC_RD = 5'h0b,
		CRF_OP_SPEC_WR = 5'h0c,
		CRF_OP_PC = 5'h0d,
		CRF_OP_SP_ADJ = 5'h0e,
		CRF_OP_SET_XM = 5'h0f,
		CRF_OP_IO_EXT = 5'h10,
		CRF_OP_ONCHIP_RD = 5'h11,
		CRF_OP_ONCHIP_WR = 5'h12,
		CRF_OP_MEM_REF = 5'h13,
		CRF_OP_VEC = 5'h14
	} crf_op_t;

	typedef enum logic [2:0] {
		CRF_REG_AF = 3'h0,
		CRF_REG_BC = 3'h1,
		CRF_REG_DE = 3'h2,
		CRF_REG_HL = 3'h3,
		CRF_REG_IX = 3'h4,
		CRF_REG_IY = 3'h5
	} crf_reg_t;

	typedef enum logic [1:0] {
		CRF_SZ_LO8 = 2'h0,
		CRF_SZ_HI8 = 2'h1,
		CRF_SZ_WORD = 2'h2,
		CRF_SZ_LONG = 2'h3
	} crf_size_t;

	typedef enum logic [1:0] {
		CRF_ST_IDLE = 2'h0,
		CRF_ST_RD = 2'h1,
		CRF_ST_X2 = 2'h2,
		CRF_ST_X3 = 2'h3
	} crf_state_t;

	// ==========================================================
	// request and answer bundles
	typedef struct packed {
		logic valid;
		crf_op_t op;
		crf_reg_t sel;
		crf_size_t size;
		logic [2:0] sub;
		logic [15:0] aux;
		logic [31:0] wdata;
	} crf_req_t;

	typedef struct packed {
		logic done;
		logic [31:0] data;
	} crf_rsp_t;

	typedef struct packed {
		logic [31:0] addr;
		logic strobe;
		logic pseudo;
	} crf_io_t;

	typedef struct packed {
		logic [31:0] addr;
		logic valid;
		logic aligned;
		logic [15:0] lanes;
	} crf_mem_t;

endpackage
